/* File: verilog/pev_defs.vh */
`ifndef PEV_DEFS_VH
`define PEV_DEFS_VH
// Status word field positions.
`define PEV_SR_TRACE 15
`define PEV_SR_SUPER 13
`define PEV_SR_MASK_HI 10
`define PEV_SR_MASK_LO 8
`define PEV_SR_RESET 16'h2700
// Reference class codes.
`define PEV_FC_UD 3'h1
`define PEV_FC_UP 3'h2
`define PEV_FC_SD 3'h5
`define PEV_FC_SP 3'h6
`define PEV_FC_IACK 3'h7
// Fixed vector numbers.
`define PEV_VEC_RESET 8'h00
`define PEV_VEC_BUSERR 8'h02
`define PEV_VEC_ADRERR 8'h03
`define PEV_VEC_ILLEGAL 8'h04
`define PEV_VEC_ZDIV 8'h05
`define PEV_VEC_BOUNDS 8'h06
`define PEV_VEC_OVF 8'h07
`define PEV_VEC_PRIV 8'h08
`define PEV_VEC_TRACE 8'h09
`define PEV_VEC_LINE_A 8'h0A
`define PEV_VEC_LINE_F 8'h0B
`define PEV_VEC_UNINIT 8'h0F
`define PEV_VEC_SPUR 8'h18
`define PEV_VEC_AUTO0 8'h18
`define PEV_VEC_TRAP0 8'h20
// Exception causes.
`define PEV_EX_NONE 4'h0
`define PEV_EX_BUSERR 4'h1
`define PEV_EX_ADRERR 4'h2
`define PEV_EX_ILLEGAL 4'h3
`define PEV_EX_ZDIV 4'h4
`define PEV_EX_BOUNDS 4'h5
`define PEV_EX_OVF 4'h6
`define PEV_EX_TRAP 4'h7
`define PEV_EX_LINE_A 4'h8
`define PEV_EX_LINE_F 4'h9
`define PEV_EX_INT 4'hA
`define PEV_EX_SPUR 4'hB
`define PEV_EX_UNINIT 4'hC
`define PEV_EX_PRIV 4'hD
`endif

/* File: verilog/pev_core.v */
`timescale 1ns/100ps
// Behaviour
// - Status supervisor flag selects privilege state.
// - Supervisor state allows all, marks supervisor.
// - Stack accesses pick pointer by state.
// - Exception handling always supervisor, supervisor stack.
// - User state refuses privileged instructions.
// - User instruction cycles marked user class.
// - Enter supervisor only through exceptions; the code also loads an idle status write or return unless an entry starts in that cycle.
// - Leave supervisor via return or status write.
// - Three class lines carry documented codes.
// - Step one copies status, sets flags.
// - Step two gets vector number.
// - Vector address is number times four.
// - Entries two words, reset four program.
// - Table spans 1024 bytes, reset at 0.
// - Internal faults use fixed vector addresses.
// - Uninitialised, spurious and autovector numbers.
// - Trap and user vector ranges.
// - Trace raises exception after each instruction; the code drops it when another cause comes in the same cycle.
// - External and internal exception causes.
// - Reset forces supervisor, mask seven, no save.
// - Non-reset entry pushes counter and status.
`include "pev_defs.vh"

module pev_core (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_insn_done,
  input  wire        i_insn_priv,
  input  wire        i_sr_write,
  input  wire [15:0] i_sr_value,
  input  wire        i_return_from_handler,
  input  wire        i_stack_access,
  input  wire        i_bus_cycle,
  input  wire        i_bus_program,
  input  wire [3:0]  i_cause,
  input  wire [3:0]  i_trap_num,
  input  wire        i_autovector,
  input  wire [2:0]  i_int_level,
  input  wire        i_bus_done,
  input  wire [7:0]  i_data_low,
  output reg  [15:0] o_status,
  output reg         o_supervisor,
  output reg         o_use_system_stack,
  output reg         o_reference_class_line_2,
  output reg         o_reference_class_line_1,
  output reg         o_reference_class_line_0,
  output reg         o_priv_refuse,
  output reg  [15:0] o_saved_status,
  output reg  [23:0] o_vector_addr,
  output reg  [2:0]  o_step,
  output reg         o_fetch_vector,
  output reg         o_push_context,
  output reg         o_busy
);

  //--------------------------------------------------------------------
  // Reset synchroniser and state codes
  //--------------------------------------------------------------------
  // ST_IDLE runs instructions. ST_COPY, ST_VEC, ST_PUSH and ST_LOAD are
  // the four entry steps. ST_RST fetches the initial stack pointer after
  // reset; ST_LOAD then fetches the initial counter, and the reset entry
  // never passes through the push step.
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_COPY = 3'h1;
  localparam [2:0] ST_VEC  = 3'h2;
  localparam [2:0] ST_PUSH = 3'h3;
  localparam [2:0] ST_LOAD = 3'h4;
  localparam [2:0] ST_RST  = 3'h5;

  // is_reset marks the reset entry, whose fetches use program space and
  // which never pushes; cause_q holds the cause taken in idle, so a
  // cause line that drops during entry cannot change the vector.
  reg        rst_meta;
  reg        rst_sync;
  reg        is_reset;
  reg  [3:0] cause_q;
  reg  [7:0] next_vec;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [2:0] next_class;
  wire       in_exc;
  wire       user_priv;

  // Release the async reset through two flops.
  // Assertion acts at once; release waits two edges so that no flop
  // leaves reset too close to a clock edge.
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  // Vector number times four, widened to a full bus address.
  // The top fourteen bits are always zero: the table is 1024 bytes.
  function [23:0] vec_to_addr;
    input [7:0] num;
    begin
      vec_to_addr = {14'h0000, num, 2'b00};
    end
  endfunction

  // Internal vector number for a cause; vectored interrupts use the bus value.
  // Trace is the default, as the only entry with no cause code.
  // Reserved vector numbers are never produced here.
  function [7:0] cause_vec;
    input [3:0] c;
    input [3:0] tn;
    input [2:0] lvl;
    begin
      case (c)
        `PEV_EX_BUSERR:  cause_vec = `PEV_VEC_BUSERR;
        `PEV_EX_ADRERR:  cause_vec = `PEV_VEC_ADRERR;
        `PEV_EX_ILLEGAL: cause_vec = `PEV_VEC_ILLEGAL;
        `PEV_EX_ZDIV:    cause_vec = `PEV_VEC_ZDIV;
        `PEV_EX_BOUNDS:  cause_vec = `PEV_VEC_BOUNDS;
        `PEV_EX_OVF:     cause_vec = `PEV_VEC_OVF;
        `PEV_EX_LINE_A:  cause_vec = `PEV_VEC_LINE_A;
        `PEV_EX_LINE_F:  cause_vec = `PEV_VEC_LINE_F;
        `PEV_EX_PRIV:    cause_vec = `PEV_VEC_PRIV;
        `PEV_EX_TRAP:    cause_vec = `PEV_VEC_TRAP0 + {4'h0, tn};
        `PEV_EX_SPUR:    cause_vec = `PEV_VEC_SPUR;
        `PEV_EX_UNINIT:  cause_vec = `PEV_VEC_UNINIT;
        `PEV_EX_INT:     cause_vec = `PEV_VEC_AUTO0 + {5'h00, lvl};
        default:         cause_vec = `PEV_VEC_TRACE;
      endcase
    end
  endfunction

  // in_exc is high in every entry step; user_priv flags a privileged
  // attempt from user state, which must trap instead of running.
  assign in_exc    = (state != ST_IDLE);
  assign user_priv = !o_status[`PEV_SR_SUPER] && i_insn_priv;

  // Vector number for the current entry: the bus value for a vectored
  // interrupt, otherwise the number generated for the cause.
  always @* begin
    if (cause_q == `PEV_EX_INT && !i_autovector) begin
      next_vec = i_data_low;
    end else begin
      next_vec = cause_vec(cause_q, i_trap_num, i_int_level);
    end
  end

  //--------------------------------------------------------------------
  // Exception sequencer
  //--------------------------------------------------------------------
  // Steps: copy status, find vector, push context, load new context.
  // Causes are ignored while an entry runs: one entry at a time.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // Trace is taken once the instruction completes, as an internal
        // interrupt that no other cause is standing against.
        if (user_priv || (i_cause != `PEV_EX_NONE) ||
            (i_insn_done && o_status[`PEV_SR_TRACE])) begin
          next_state = ST_COPY;
        end
      end
      ST_COPY: next_state = ST_VEC;
      ST_VEC: begin
        // A vectored interrupt waits for its acknowledge transfer to end;
        // every other cause passes straight through.
        if ((cause_q != `PEV_EX_INT) || i_autovector || i_bus_done) begin
          next_state = is_reset ? ST_LOAD : ST_PUSH;
        end
      end
      ST_PUSH: if (i_bus_done) next_state = ST_LOAD;
      ST_LOAD: if (i_bus_done) next_state = is_reset ? ST_RST : ST_IDLE;
      ST_RST:  if (i_bus_done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer registers and status word.
  always @(posedge i_ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state          <= ST_RST;
      // Reset starts at the stack pointer fetch with mask seven.
      is_reset       <= 1'b1;
      cause_q        <= `PEV_EX_NONE;
      o_status       <= `PEV_SR_RESET;
      o_saved_status <= 16'h0000;
      o_vector_addr  <= 24'h000000;
    end else begin
      state <= next_state;
      if (state == ST_RST && i_bus_done) begin
        // The initial counter follows the initial stack pointer.
        state         <= ST_LOAD;
        o_vector_addr <= 24'h000004;
      end
      // The reset entry ends once the initial counter is fetched; clearing
      // is_reset lets later entries push and use data space.
      if (state == ST_LOAD && is_reset && i_bus_done) begin
        state    <= ST_IDLE;
        is_reset <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (next_state == ST_COPY) begin
            is_reset <= 1'b0;
            // A privileged attempt wins over other causes, so the
            // refused instruction never runs.
            if (user_priv)
              cause_q <= `PEV_EX_PRIV;
            else if (i_cause != `PEV_EX_NONE)
              cause_q <= i_cause;
            else
              cause_q <= `PEV_EX_NONE;
          end else if (i_sr_write || i_return_from_handler) begin
            // Writes land only in idle; during entry the sequencer owns
            // the status word.
            o_status <= i_sr_value;
          end
        end
        ST_COPY: begin
          o_saved_status <= o_status;
          o_status[`PEV_SR_SUPER] <= 1'b1;
          o_status[`PEV_SR_TRACE] <= 1'b0;
          // The mask follows the level only for interrupts; reset has
          // already loaded it with seven.
          if (cause_q == `PEV_EX_INT)
            o_status[`PEV_SR_MASK_HI:`PEV_SR_MASK_LO] <= i_int_level;
        end
        ST_VEC: begin
          // The table address settles here; a vectored interrupt keeps
          // the value that stands on the data lines when its transfer
          // ends, since that is the last write of the step.
          o_vector_addr <= vec_to_addr(next_vec);
        end
        default: begin
        end
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Privilege, stack and reference class outputs
  //--------------------------------------------------------------------
  // Class code for the current reference.
  // Reset fetches use program space; pushes and other vector fetches
  // use data space.
  always @* begin
    if (state == ST_VEC && cause_q == `PEV_EX_INT)
      next_class = `PEV_FC_IACK;
    else if (in_exc)
      next_class = (is_reset && state != ST_PUSH) ?
                   `PEV_FC_SP : `PEV_FC_SD;
    else if (o_status[`PEV_SR_SUPER])
      next_class = i_bus_program ? `PEV_FC_SP : `PEV_FC_SD;
    else
      next_class = i_bus_program ? `PEV_FC_UP : `PEV_FC_UD;
  end

  // Registered outputs.
  // Each output is a flop, so it shows the state of the cycle before.
  // Consumers must allow for that one cycle of lag.
  // Checks of privilege against the status word must do the same.
  always @(posedge i_ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      // Out of reset the block shows the reset stack pointer fetch.
      o_supervisor             <= 1'b1;
      o_use_system_stack       <= 1'b1;
      o_reference_class_line_2 <= 1'b1;
      o_reference_class_line_1 <= 1'b1;
      o_reference_class_line_0 <= 1'b0;
      o_priv_refuse            <= 1'b0;
      o_step                   <= ST_RST;
      o_fetch_vector           <= 1'b0;
      o_push_context           <= 1'b0;
      o_busy                   <= 1'b1;
    end else begin
      // Entry always uses the system stack; otherwise the state picks it.
      o_supervisor <= o_status[`PEV_SR_SUPER] || in_exc;
      o_use_system_stack <= in_exc || (i_stack_access &&
                            o_status[`PEV_SR_SUPER]);
      // The lines change only on a bus cycle or during entry, so an idle bus
      // keeps showing a stable, used code.
      if (i_bus_cycle || in_exc) begin
        o_reference_class_line_2 <= next_class[2];
        o_reference_class_line_1 <= next_class[1];
        o_reference_class_line_0 <= next_class[0];
      end
      o_priv_refuse  <= (state == ST_IDLE) && user_priv;
      o_step         <= state;
      // Vector fetches are the load and reset steps; pushes are step three.
      o_fetch_vector <= (state == ST_LOAD) || (state == ST_RST);
      o_push_context <= (state == ST_PUSH);
      o_busy         <= in_exc;
    end
  end

endmodule // pev_core

/* File: tb/pev_chk.sv */
`timescale 1ns/100ps
`include "pev_defs.vh"
// ---
// Port checker
// ---
module pev_chk (
  input wire        i_ref_clk,
  input wire        i_rst_n,
  input wire        i_insn_priv,
  input wire        i_sr_write,
  input wire        i_return_from_handler,
  input wire        i_stack_access,
  input wire [15:0] o_status,
  input wire        o_supervisor,
  input wire        o_use_system_stack,
  input wire        o_reference_class_line_2,
  input wire        o_reference_class_line_1,
  input wire        o_reference_class_line_0,
  input wire        o_priv_refuse,
  input wire [23:0] o_vector_addr,
  input wire [2:0]  o_step,
  input wire        o_fetch_vector,
  input wire        o_push_context,
  input wire        o_busy
);
  wire [2:0] cls;
  // Gather the three class lines into one code.
  assign cls = {o_reference_class_line_2, o_reference_class_line_1,
                o_reference_class_line_0};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_cls; !(cls == 3'h0 || cls == 3'h3 || cls == 3'h4); endproperty
  a_cls: assert property (p_cls) else $error("unused class code");
  property p_sup; !o_busy |-> o_supervisor == $past(o_status[13]);
  endproperty
  a_sup: assert property (p_sup) else $error("state flag mismatch");
  property p_exc; o_busy && o_step != 3'h1 |-> o_supervisor && cls[2];
  endproperty
  a_exc: assert property (p_exc) else $error("user class in entry");
  property p_stk;
    $past(i_stack_access) && !o_busy |->
      o_use_system_stack == $past(o_status[13]);
  endproperty
  a_stk: assert property (p_stk) else $error("wrong stack pointer");
  property p_push; o_push_context |-> o_use_system_stack; endproperty
  a_push: assert property (p_push) else $error("push on user stack");
  property p_in; $rose(o_status[13]) |-> o_busy || $past(o_busy); endproperty
  a_in: assert property (p_in) else $error("entry outside handling");
  property p_out;
    $fell(o_status[13]) |-> $past(i_sr_write || i_return_from_handler);
  endproperty
  a_out: assert property (p_out) else $error("bad supervisor exit");
  property p_addr; o_vector_addr[1:0] == 2'h0 && o_vector_addr[23:10] == 14'h0;
  endproperty
  a_addr: assert property (p_addr) else $error("bad vector address");
  property p_ack;
    cls == `PEV_FC_IACK |-> o_busy && o_step == 3'h2 && !o_fetch_vector;
  endproperty
  a_ack: assert property (p_ack) else $error("stray acknowledge");
  property p_ref;
    i_insn_priv && !o_status[13] && !o_busy |-> ##[1:2] o_priv_refuse;
  endproperty
  a_ref: assert property (p_ref) else $error("no refusal");
endmodule // pev_chk

/* File: tb/pev_partner.sv */
`timescale 1ns/100ps
`include "pev_defs.vh"
// ---
// Bus and peripheral model
// ---
module pev_partner (
  input  wire       i_ref_clk,
  input  wire       i_busy,
  input  wire [2:0] i_step,
  input  wire [2:0] i_class,
  input  wire [7:0] i_vec,
  input  wire [3:0] i_wait,
  output reg        o_bus_done,
  output reg  [7:0] o_data_low
);
  reg [2:0] last;
  reg [3:0] cnt;
  initial begin
    o_bus_done = 1'b0;
    last       = 3'h0;
    cnt        = 4'h0;
  end
  // Each step's transfer ends once after the set number of wait cycles.
  always @(posedge i_ref_clk) begin
    last       <= i_step;
    o_bus_done <= 1'b0;
    cnt        <= (i_step != last) ? 4'h0 : cnt + 4'h1;
    if (i_busy && i_step == last && cnt == i_wait)
      o_bus_done <= 1'b1;
  end
  // Vector only while acknowledged; otherwise the lines show its inverse.
  always @*
    o_data_low = (i_class == `PEV_FC_IACK) ? i_vec : ~i_vec;
endmodule // pev_partner

/* File: tb/tb_pev_core.sv */
`timescale 1ns/100ps
`include "pev_defs.vh"
module tb_pev_core;
  reg         clk, rst_n, done, priv, srw, ret, stk, bcyc, bprog, auto;
  reg  [15:0] srv;
  reg  [3:0]  cause, tn, wt;
  reg  [2:0]  lvl;
  reg  [7:0]  vec;
  wire [7:0]  dl;
  wire [15:0] st, sav;
  wire [23:0] va;
  wire [2:0]  step;
  wire        bd, sup, uss, c2, c1, c0, refuse, fv, pc, busy;
  integer     bad_count, n_compared, i;
  pev_core i_pev_core (.i_ref_clk(clk), .i_rst_n(rst_n), .i_insn_done(done),
    .i_insn_priv(priv), .i_sr_write(srw), .i_sr_value(srv),
    .i_return_from_handler(ret), .i_stack_access(stk), .i_bus_cycle(bcyc),
    .i_bus_program(bprog), .i_cause(cause), .i_trap_num(tn),
    .i_autovector(auto), .i_int_level(lvl), .i_bus_done(bd),
    .i_data_low(dl), .o_status(st), .o_supervisor(sup),
    .o_use_system_stack(uss), .o_reference_class_line_2(c2),
    .o_reference_class_line_1(c1), .o_reference_class_line_0(c0),
    .o_priv_refuse(refuse), .o_saved_status(sav), .o_vector_addr(va),
    .o_step(step), .o_fetch_vector(fv), .o_push_context(pc), .o_busy(busy));
  pev_partner i_pev_partner (.i_ref_clk(clk), .i_busy(busy), .i_step(step),
    .i_class({c2, c1, c0}), .i_vec(vec), .i_wait(wt), .o_bus_done(bd),
    .o_data_low(dl));
  task tick; begin @(posedge clk); #1; end endtask
  task chk(input [23:0] got, input [23:0] exp); begin
    n_compared = n_compared + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task wait_idle; begin
    tick;
    i = 0;
    while (busy !== 1'b0 && i < 200) begin tick; i = i + 1; end
    chk(busy, 1'b0);
  end endtask
  task set_sr(input [15:0] v); begin
    srv = v; srw = 1'b1; tick; srw = 1'b0; tick; tick;
  end endtask
  // Mode 0 raises a cause, 1 traces, 2 tries a privileged op from user state.
  task run_exc(input [1:0] md, input [3:0] c, input [3:0] t, input [7:0] v,
               input [2:0] l, input a, input [23:0] exp); begin
    set_sr(16'h8000);
    wt = wt ^ 4'h3; tn = t; vec = v; lvl = l; auto = a;
    cause = (md == 2'h0) ? c : 4'h0; done = (md == 2'h1); priv = (md == 2'h2);
    tick; cause = 4'h0; done = 1'b0; priv = 1'b0;
    wait_idle;
    chk(va, exp);
    chk(sav, 16'h8000);
    chk({st[15], st[13]}, 2'h1);
    if (c != `PEV_EX_SPUR && c != `PEV_EX_UNINIT)
      chk(st[10:8], (c == `PEV_EX_INT) ? l : 3'h0);
  end endtask
  task report_and_stop; begin
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  end endtask
  initial begin clk = 1'b0; forever #50 clk = ~clk; end
  initial begin #400000; bad_count = bad_count + 1; report_and_stop; end
  initial begin
    {rst_n, done, priv, srw, ret, stk, bcyc, bprog, auto} = 9'h0;
    srv = 16'h0; cause = 4'h0; tn = 4'h0; wt = 4'h0; lvl = 3'h0; vec = 8'h0;
    bad_count = 0; n_compared = 0;
    repeat (10) tick;
    chk({st, step, c2, c1, c0}, {16'h2700, 3'h5, `PEV_FC_SP});
    chk(va, 24'h0);
    rst_n = 1'b1;
    i = 0;
    while (step !== 3'h4 && i < 100) begin tick; i = i + 1; end
    chk(va, 24'h4);
    wait_idle;
    // Vectors below avoid the reserved numbers.
    run_exc(0, `PEV_EX_BUSERR, 0, 0, 0, 0, 24'h8);
    run_exc(0, `PEV_EX_ADRERR, 0, 0, 0, 0, 24'hC);
    run_exc(0, `PEV_EX_ILLEGAL, 0, 0, 0, 0, 24'h10);
    run_exc(0, `PEV_EX_ZDIV, 0, 0, 0, 0, 24'h14);
    run_exc(0, `PEV_EX_BOUNDS, 0, 0, 0, 0, 24'h18);
    run_exc(0, `PEV_EX_OVF, 0, 0, 0, 0, 24'h1C);
    run_exc(0, `PEV_EX_LINE_A, 0, 0, 0, 0, 24'h28);
    run_exc(0, `PEV_EX_LINE_F, 0, 0, 0, 0, 24'h2C);
    run_exc(0, `PEV_EX_UNINIT, 0, 0, 0, 0, 24'h3C);
    run_exc(0, `PEV_EX_SPUR, 0, 0, 0, 0, 24'h60);
    run_exc(0, `PEV_EX_TRAP, 0, 0, 0, 0, 24'h80);
    run_exc(0, `PEV_EX_TRAP, 15, 0, 0, 0, 24'hBC);
    run_exc(0, `PEV_EX_INT, 0, 0, 1, 1, 24'h64);
    run_exc(0, `PEV_EX_INT, 0, 0, 7, 1, 24'h7C);
    run_exc(0, `PEV_EX_INT, 0, 8'h40, 2, 0, 24'h100);
    run_exc(0, `PEV_EX_INT, 0, 8'hFF, 5, 0, 24'h3FC);
    run_exc(1, 0, 0, 0, 0, 0, 24'h24);
    run_exc(2, 0, 0, 0, 0, 0, 24'h20);
    // Supervisor cases first; a return then leaves for the user cases.
    for (i = 0; i < 4; i = i + 1) begin
      if (i == 2) begin
        srv = 16'h0; ret = 1'b1; tick; ret = 1'b0; tick; tick;
        chk(st[13], 1'b0);
      end else if (i < 2) begin
        set_sr(16'h2000);
      end
      bprog = i[0]; bcyc = 1'b1; stk = 1'b1; tick; tick;
      chk({c2, c1, c0}, {~i[1], i[0], ~i[0]});
      chk({sup, uss}, {2{~i[1]}});
    end
    report_and_stop;
  end
endmodule // tb_pev_core
bind pev_core pev_chk i_pev_chk (.i_ref_clk, .i_rst_n, .i_insn_priv,
  .i_sr_write, .i_return_from_handler, .i_stack_access, .o_status,
  .o_supervisor, .o_use_system_stack, .o_reference_class_line_2,
  .o_reference_class_line_1, .o_reference_class_line_0, .o_priv_refuse,
  .o_vector_addr, .o_step, .o_fetch_vector, .o_push_context, .o_busy);
